// ### logic/tmrch_defines.vh
`ifndef TMRCH_DEFINES_VH
`define TMRCH_DEFINES_VH

// ==========================================================
// register byte addresses
// ==========================================================
`define TMRCH_ADDR_MODE_CONFIG 12'h000
`define TMRCH_ADDR_MODE_EXTRA 12'h004
`define TMRCH_ADDR_DATA 12'h008
`define TMRCH_ADDR_COUNTER 12'h00c
`define TMRCH_ADDR_TRIGGER 12'h010
`define TMRCH_ADDR_STATUS 12'h014
`define TMRCH_ADDR_CLEAR 12'h018

// ==========================================================
// reset values
// ==========================================================
`define TMRCH_RST_MODE_CONFIG 16'h0000
`define TMRCH_RST_MODE_EXTRA 16'h0000
`define TMRCH_RST_DATA 32'h0000_0000

// ==========================================================
// mode config field positions
// ==========================================================
`define TMRCH_CKS_HI 15
`define TMRCH_CKS_LO 14
`define TMRCH_CCS_HI 13
`define TMRCH_CCS_LO 12
`define TMRCH_MAS_BIT 11
`define TMRCH_STS_HI 10
`define TMRCH_STS_LO 8
`define TMRCH_COS_HI 7
`define TMRCH_COS_LO 6
`define TMRCH_MD_HI 4
`define TMRCH_MD_LO 1
`define TMRCH_MD0_BIT 0

// mode extra field positions
`define TMRCH_TIS_HI 1
`define TMRCH_TIS_LO 0

// trigger, status and clear bit positions
`define TMRCH_TRIG_START_BIT 0
`define TMRCH_TRIG_STOP_BIT 1
`define TMRCH_STAT_EN_BIT 0
`define TMRCH_STAT_OVF_BIT 1
`define TMRCH_STAT_OUT_BIT 2
`define TMRCH_CLR_OVF_BIT 0

// ==========================================================
// field encodings
// ==========================================================
`define TMRCH_MD_INTERVAL 4'h0
`define TMRCH_MD_CAPTURE 4'h2
`define TMRCH_MD_ONE_COUNT 4'h4
`define TMRCH_MD_CAP_ONE 4'h6
`define TMRCH_MD_CNT_CAPTURE 4'h5
`define TMRCH_MD_CAP_GATE 4'h9
`define TMRCH_MD_GATE_COUNT 4'hc
`define TMRCH_CCS_OPCLK 2'h0
`define TMRCH_STS_SOFTWARE 3'h0
`define TMRCH_TIS_FALL 2'h0
`define TMRCH_TIS_RISE 2'h1
`define TMRCH_TIS_BOTH 2'h2

// counter limits
`define TMRCH_CNT_ZERO 32'h0000_0000
`define TMRCH_CNT_ONES 32'hffff_ffff

`endif

// ### logic/tmrch_edge_det.v
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// input pin synchroniser and edge detector on operation clock
// ==========================================================
module tmrch_edge_det (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // pin and control
    input wire pin_in,
    input wire op_tick,
    input wire [1:0] edge_sel,
    // result
    output reg edge_seen
);

`include "tmrch_defines.vh"

reg sync1_reg; // first synchroniser stage
reg sync2_reg; // second synchroniser stage
reg samp_reg; // level seen at last operation clock tick
wire rise; // rising edge at this tick
wire fall; // falling edge at this tick

// two flops before anything reads the pin
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1_reg <= 1'b0;
        sync2_reg <= 1'b0;
    end else begin
        sync1_reg <= pin_in;
        sync2_reg <= sync1_reg;
    end
end

assign rise = sync2_reg & ~samp_reg;
assign fall = ~sync2_reg & samp_reg;

// sample only on the operation clock, so an edge lags by one tick at most
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        samp_reg <= 1'b0;
        edge_seen <= 1'b0;
    end else if (op_tick) begin
        samp_reg <= sync2_reg;
        // edge select picks which transition counts
        if (edge_sel == `TMRCH_TIS_RISE) begin
            edge_seen <= rise;
        end else if (edge_sel == `TMRCH_TIS_BOTH) begin
            edge_seen <= rise | fall;
        end else if (edge_sel == `TMRCH_TIS_FALL) begin
            edge_seen <= fall;
        end else begin
            edge_seen <= 1'b0;
        end
    end else begin
        edge_seen <= 1'b0; // one-cycle pulse
    end
end

endmodule // tmrch_edge_det

`default_nettype wire

// ### logic/tmrch_channel.v
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// timer channel, interval mode plus up-count overflow flag
// ==========================================================

module tmrch_channel (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb request
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // apb answer
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // prescaler ticks, one pclk cycle wide
    input wire prescaler_clock_0,
    input wire prescaler_clock_1,
    input wire prescaler_clock_2,
    input wire prescaler_clock_3,
    // timer pins
    input wire timer_in_pin,
    output reg square_wave_out,
    // interrupt
    output reg channel_irq
);

`include "tmrch_defines.vh"

// ==========================================================
// helper functions
// ==========================================================

// modes whose counter runs upward
function is_up_mode;
    input [3:0] md;
    begin
        is_up_mode = (md == `TMRCH_MD_CAPTURE) || (md == `TMRCH_MD_CAP_ONE) ||
            (md == `TMRCH_MD_CNT_CAPTURE) || (md == `TMRCH_MD_CAP_GATE);
    end
endfunction

// modes that may raise an interrupt at counter start
function start_irq_allowed;
    input [3:0] md;
    begin
        start_irq_allowed = (md != `TMRCH_MD_ONE_COUNT) && (md != `TMRCH_MD_GATE_COUNT);
    end
endfunction

// modes that report an overflow in the status flag
function ovf_flag_mode;
    input [3:0] md;
    begin
        ovf_flag_mode = (md == `TMRCH_MD_CNT_CAPTURE) || (md == `TMRCH_MD_CAP_GATE);
    end
endfunction

// ==========================================================
// registers and nets
// ==========================================================
reg [15:0] mode_config_reg; // clock, trigger and mode selection
reg [15:0] mode_extra_reg; // input edge selection
reg [31:0] data_reg; // channel data register
reg [31:0] counter_reg; // channel counter
reg [31:0] counter_next; // counter value for next edge
reg enabled_reg; // channel enabled flag
reg start_pend_reg; // start waiting for its start event, count tick or pin edge
reg overflow_reg; // overflow status flag
reg irq_next; // interrupt for next edge
reg toggle_next; // output toggle for next edge
reg ovf_set; // overflow seen this cycle
reg cap_load; // capture into data register this cycle
reg start_pend_next; // pending start for next edge

wire wr_en; // apb write access phase
wire rd_en; // apb read access phase
wire addr_hit; // address decodes to a register
wire start_wr; // start trigger written with 1
wire stop_wr; // stop trigger written with 1
wire clr_ovf_wr; // overflow clear command written with 1
wire [1:0] cks; // operation clock select
wire [1:0] ccs; // count clock select
wire [2:0] sts; // start trigger select
wire [3:0] md; // operation mode field
wire md0; // start interrupt select
wire [1:0] tis; // input edge select
reg op_tick; // selected operation clock tick
wire in_edge; // valid input edge
wire cnt_tick; // count clock tick
wire start_event; // counter may start now
wire up_mode; // counting direction

// ==========================================================
// field extraction
// ==========================================================
assign cks = mode_config_reg[`TMRCH_CKS_HI:`TMRCH_CKS_LO];
assign ccs = mode_config_reg[`TMRCH_CCS_HI:`TMRCH_CCS_LO];
assign sts = mode_config_reg[`TMRCH_STS_HI:`TMRCH_STS_LO];
assign md = mode_config_reg[`TMRCH_MD_HI:`TMRCH_MD_LO];
assign md0 = mode_config_reg[`TMRCH_MD0_BIT];
assign tis = mode_extra_reg[`TMRCH_TIS_HI:`TMRCH_TIS_LO];
// interval mode, code zero, is a down mode like one and gate count
assign up_mode = is_up_mode(md);

// ==========================================================
// apb decode
// ==========================================================
assign pready = 1'b1; // zero wait states
assign wr_en = psel & penable & pwrite;
assign rd_en = psel & penable & ~pwrite;

// unmapped addresses give an error answer
assign addr_hit = (paddr == `TMRCH_ADDR_MODE_CONFIG) || (paddr == `TMRCH_ADDR_MODE_EXTRA) ||
    (paddr == `TMRCH_ADDR_DATA) || (paddr == `TMRCH_ADDR_COUNTER) ||
    (paddr == `TMRCH_ADDR_TRIGGER) || (paddr == `TMRCH_ADDR_STATUS) ||
    (paddr == `TMRCH_ADDR_CLEAR);
assign pslverr = psel & penable & ~addr_hit;

// trigger bits act only on the write, they store nothing
assign start_wr = wr_en && (paddr == `TMRCH_ADDR_TRIGGER) && pwdata[`TMRCH_TRIG_START_BIT];
assign stop_wr = wr_en && (paddr == `TMRCH_ADDR_TRIGGER) && pwdata[`TMRCH_TRIG_STOP_BIT];
assign clr_ovf_wr = wr_en && (paddr == `TMRCH_ADDR_CLEAR) && pwdata[`TMRCH_CLR_OVF_BIT];

// ==========================================================
// configuration registers
// ==========================================================
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mode_config_reg <= `TMRCH_RST_MODE_CONFIG;
        mode_extra_reg <= `TMRCH_RST_MODE_EXTRA;
    end else if (wr_en) begin
        // unused fields are stored as written; software keeps them zero
        if (paddr == `TMRCH_ADDR_MODE_CONFIG) begin
            mode_config_reg <= pwdata[15:0];
        end else if (paddr == `TMRCH_ADDR_MODE_EXTRA) begin
            mode_extra_reg <= pwdata[15:0];
        end
    end
end

// data register, written any time, capture also lands here
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        data_reg <= `TMRCH_RST_DATA;
    end else if (wr_en && (paddr == `TMRCH_ADDR_DATA)) begin
        data_reg <= pwdata;
    end else if (cap_load) begin
        data_reg <= counter_reg;
    end
end

// ==========================================================
// clock selection
// ==========================================================

// operation clock is one of four prescaler ticks
always @* begin
    if (cks == 2'h0) begin
        op_tick = prescaler_clock_0;
    end else if (cks == 2'h1) begin
        op_tick = prescaler_clock_1;
    end else if (cks == 2'h2) begin
        op_tick = prescaler_clock_2;
    end else begin
        op_tick = prescaler_clock_3;
    end
end

// input pin edge detection on the operation clock
tmrch_edge_det u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(timer_in_pin),
    .op_tick(op_tick),
    .edge_sel(tis),
    .edge_seen(in_edge)
);

// count clock is the operation clock, or else the input edge
assign cnt_tick = (ccs == `TMRCH_CCS_OPCLK) ? op_tick : in_edge;

// software start waits for the count clock, other starts for the pin
// the load and any start pulse both land on that same edge
assign start_event = (sts == `TMRCH_STS_SOFTWARE) ? cnt_tick : in_edge;

// ==========================================================
// counter next state
// ==========================================================
always @* begin
    counter_next = counter_reg;
    irq_next = 1'b0;
    toggle_next = 1'b0;
    ovf_set = 1'b0;
    cap_load = 1'b0;
    start_pend_next = start_pend_reg;
    if (start_wr) begin
        // start, or forced restart while running
        start_pend_next = 1'b1;
    end else if (stop_wr) begin
        start_pend_next = 1'b0;
    end else if (enabled_reg && start_pend_reg && start_event) begin
        // first load after a start
        start_pend_next = 1'b0;
        if (up_mode) begin
            counter_next = `TMRCH_CNT_ZERO;
        end else begin
            counter_next = data_reg;
        end
        if (md0 && start_irq_allowed(md)) begin
            irq_next = 1'b1;
            toggle_next = 1'b1;
        end
        // with md0 clear the start pulse and toggle are left out
    end else if (enabled_reg && !start_pend_reg && cnt_tick) begin
        // no count while a start is pending, so a restart reloads cleanly
        if (up_mode) begin
            // up counters wrap with no interrupt
            counter_next = counter_reg + 32'h0000_0001;
            if (counter_reg == `TMRCH_CNT_ONES) begin
                ovf_set = ovf_flag_mode(md);
            end
        end else if (counter_reg == `TMRCH_CNT_ZERO) begin
            // zero reached: pulse, toggle, reload latest data
            irq_next = 1'b1;
            toggle_next = 1'b1;
            counter_next = data_reg;
        end else begin
            counter_next = counter_reg - 32'h0000_0001;
        end
        // capture modes on the operation count clock copy the count on a pin edge that meets a count tick, and restart
        if (up_mode && in_edge && (ccs == `TMRCH_CCS_OPCLK)) begin
            cap_load = 1'b1;
            counter_next = `TMRCH_CNT_ZERO;
        end
    end
end

// ==========================================================
// channel state registers
// ==========================================================
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        counter_reg <= `TMRCH_CNT_ZERO;
        enabled_reg <= 1'b0;
        start_pend_reg <= 1'b0;
    end else begin
        counter_reg <= counter_next;
        start_pend_reg <= start_pend_next;
        // start sets the flag, stop clears it, start wins a tie
        if (start_wr) begin
            enabled_reg <= 1'b1;
        end else if (stop_wr) begin
            enabled_reg <= 1'b0;
        end
    end
end

// interrupt pulse and square wave output
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        channel_irq <= 1'b0;
        square_wave_out <= 1'b0;
    end else begin
        channel_irq <= irq_next;
        if (toggle_next) begin
            square_wave_out <= ~square_wave_out;
        end
    end
end

// overflow flag, a new overflow beats a clear in the same cycle
// only the two count capture modes ever set it
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        overflow_reg <= 1'b0;
    end else if (ovf_set) begin
        overflow_reg <= 1'b1;
    end else if (clr_ovf_wr) begin
        overflow_reg <= 1'b0;
    end
end

// ==========================================================
// read data
// ==========================================================
// nothing here has a side effect, so reads may repeat
always @* begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
        if (paddr == `TMRCH_ADDR_MODE_CONFIG) begin
            prdata = {16'h0000, mode_config_reg};
        end else if (paddr == `TMRCH_ADDR_MODE_EXTRA) begin
            prdata = {16'h0000, mode_extra_reg};
        end else if (paddr == `TMRCH_ADDR_DATA) begin
            prdata = data_reg;
        end else if (paddr == `TMRCH_ADDR_COUNTER) begin
            prdata = counter_reg;
        end else if (paddr == `TMRCH_ADDR_STATUS) begin
            prdata[`TMRCH_STAT_EN_BIT] = enabled_reg;
            prdata[`TMRCH_STAT_OVF_BIT] = overflow_reg;
            prdata[`TMRCH_STAT_OUT_BIT] = square_wave_out;
        end else begin
            // trigger and clear read zero
            prdata = 32'h0000_0000;
        end
    end
end

// is kept by software pairing two channels of this kind
// a down channel loaded with all ones meets zero at the wrap

endmodule // tmrch_channel

`default_nettype wire

// ### bench/tmrch_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checker for the timer channel
// ==========================================================
module tmrch_asserts (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // ticks and pins
    input wire logic prescaler_clock_0,
    input wire logic prescaler_clock_1,
    input wire logic prescaler_clock_2,
    input wire logic prescaler_clock_3,
    input wire logic square_wave_out,
    input wire logic channel_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase of a transfer
    sequence s_acc;
        psel && penable;
    endsequence
    // access to a word beyond the map
    sequence s_bad;
        s_acc ##0 (paddr > 12'h018);
    endsequence
    // read of a command word
    sequence s_cmd_rd;
        s_acc ##0 (!pwrite && (paddr == 12'h010 || paddr == 12'h018));
    endsequence
    a_ready_high: assert property (s_acc |-> pready)
        else $error("access not answered");
    a_unmapped_err: assert property (s_bad |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (s_acc ##0 (paddr <= 12'h018 && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("mapped access flagged");
    a_unmapped_zero: assert property (s_bad ##0 !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_trig_zero: assert property (s_cmd_rd |-> prdata == 32'h0)
        else $error("command word read not zero");
    a_mode_upper: assert property (s_acc ##0 (!pwrite && paddr == 12'h000) |-> prdata[31:16] == 16'h0)
        else $error("mode upper half not zero");
    a_irq_toggles: assert property (channel_irq |-> $changed(square_wave_out))
        else $error("irq without output toggle");
    a_toggle_irq: assert property ($changed(square_wave_out) |-> channel_irq)
        else $error("output toggle without irq");
    a_irq_on_tick: assert property (channel_irq |->
        $past(prescaler_clock_0 || prescaler_clock_1 || prescaler_clock_2 || prescaler_clock_3))
        else $error("irq without a tick");
endmodule // tmrch_asserts
`default_nettype wire

// ### bench/tmrch_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// far side: input pin driver and output watcher
// ==========================================================
module tmrch_pin_model (
    // clock
    input wire logic pclk,
    // pins
    input wire logic square_wave_out,
    output logic timer_in_pin
);
    int toggles = 0; // output transitions seen
    logic out_q = 1'b0; // last output level
    initial timer_in_pin = 1'b0;
    // count output transitions
    always @(posedge pclk) begin
        if (square_wave_out !== out_q) begin
            toggles <= toggles + 1;
        end
        out_q <= square_wave_out;
    end
    // one rising and one falling pin edge
    task automatic pulse(input int hold);
        repeat (hold) @(posedge pclk);
        timer_in_pin <= 1'b1;
        repeat (hold) @(posedge pclk);
        timer_in_pin <= 1'b0;
    endtask
endmodule // tmrch_pin_model
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmrch_defines.vh"
// compare and count
`define CHK(nm, ex, gt) begin \
    num_checks++; \
    if ((gt) !== (ex)) begin \
        err_total++; \
        $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); \
    end \
end
// ==========================================================
// self-checking bench for the timer channel
// ==========================================================
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, q2;
    logic [3:0] tick; // prescaler ticks
    logic timer_in_pin, square_wave_out, channel_irq, e, o;
    int tcnt = 0, err_total = 0, num_checks = 0, c, t0;
    // mode word and start toggle expected in bit 16
    logic [16:0] tbl [6] = '{17'h1_0001, 17'h1_0005, 17'h1_000b, 17'h0_0009, 17'h0_0019, 17'h0_0000};
    tmrch_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .prescaler_clock_0(tick[0]), .prescaler_clock_1(tick[1]),
        .prescaler_clock_2(tick[2]), .prescaler_clock_3(tick[3]), .timer_in_pin(timer_in_pin),
        .square_wave_out(square_wave_out), .channel_irq(channel_irq));
    tmrch_pin_model pin (.pclk(pclk), .square_wave_out(square_wave_out),
        .timer_in_pin(timer_in_pin));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // clock k ticks every k+1 cycles
    always @(posedge pclk) begin
        tcnt <= tcnt + 1;
        tick <= {tcnt % 4 == 0, tcnt % 3 == 0, tcnt % 2 == 0, 1'b1};
    end
    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q2, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r, e);
    endtask
    // edges until next irq, bounded
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (channel_irq !== 1'b1 && n < 400);
    endtask
    task automatic conclude;
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0, q, e);
            `CHK("reset read", 32'h0, q)
            `CHK("slave error", i == 7, e)
        end
        wr(`TMRCH_ADDR_MODE_EXTRA, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(`TMRCH_ADDR_MODE_CONFIG, {16'h0, tbl[i][15:0]});
            wr(`TMRCH_ADDR_DATA, 32'd200);
            o = square_wave_out;
            wr(`TMRCH_ADDR_TRIGGER, 32'h1);
            repeat (4) @(posedge pclk);
            `CHK("start toggle", o ^ tbl[i][16], square_wave_out)
            wr(`TMRCH_ADDR_TRIGGER, 32'h2);
        end
        for (int k = 0; k < 4; k++) begin
            wr(`TMRCH_ADDR_MODE_CONFIG, 32'h1 | (k << 14));
            wr(`TMRCH_ADDR_DATA, 32'd3);
            t0 = pin.toggles;
            wr(`TMRCH_ADDR_TRIGGER, 32'h1);
            wait_irq(c);
            wait_irq(c);
            `CHK("irq period", 4 * (k + 1), c)
            wait_irq(c);
            @(posedge pclk);
            `CHK("wave toggles", 3, pin.toggles - t0)
            wr(`TMRCH_ADDR_TRIGGER, 32'h2);
        end
        wr(`TMRCH_ADDR_MODE_CONFIG, 32'h1);
        wr(`TMRCH_ADDR_DATA, 32'd1000);
        wr(`TMRCH_ADDR_TRIGGER, 32'h1);
        repeat (20) @(posedge pclk);
        wr(`TMRCH_ADDR_TRIGGER, 32'h2);
        rd(`TMRCH_ADDR_COUNTER, q);
        o = square_wave_out;
        pin.pulse(3);
        rd(`TMRCH_ADDR_COUNTER, q2);
        `CHK("frozen count", q, q2)
        `CHK("frozen out", o, square_wave_out)
        rd(`TMRCH_ADDR_STATUS, q);
        `CHK("enabled flag", 1'b0, q[0])
        wr(`TMRCH_ADDR_TRIGGER, 32'h1);
        repeat (30) @(posedge pclk);
        rd(`TMRCH_ADDR_STATUS, q);
        `CHK("enabled flag", 1'b1, q[0])
        wr(`TMRCH_ADDR_DATA, 32'd5);
        rd(`TMRCH_ADDR_COUNTER, q);
        `CHK("old reload kept", 1'b1, q > 900 && q < 1000)
        wr(`TMRCH_ADDR_TRIGGER, 32'h1);
        rd(`TMRCH_ADDR_COUNTER, q);
        `CHK("forced reload", 1'b1, q <= 5)
        wait_irq(c);
        wait_irq(c);
        `CHK("new period", 6, c)
        wr(`TMRCH_ADDR_DATA, 32'h0);
        wr(`TMRCH_ADDR_TRIGGER, 32'h1);
        repeat (4) @(posedge pclk);
        o = square_wave_out;
        @(posedge pclk);
        `CHK("irq level", 1'b1, channel_irq)
        `CHK("toggle rate", ~o, square_wave_out)
        wr(`TMRCH_ADDR_TRIGGER, 32'h2);
        wr(`TMRCH_ADDR_MODE_CONFIG, 32'h4);
        wr(`TMRCH_ADDR_TRIGGER, 32'h1);
        pin.pulse(3);
        repeat (4) @(posedge pclk);
        rd(`TMRCH_ADDR_DATA, q);
        `CHK("pin capture", 1'b1, q > 3 && q < 16)
        wr(`TMRCH_ADDR_MODE_CONFIG, 32'h1);
        wr(`TMRCH_ADDR_DATA, 32'hffff_ffff);
        wr(`TMRCH_ADDR_TRIGGER, 32'h1);
        rd(`TMRCH_ADDR_COUNTER, q);
        `CHK("all ones load", 1'b1, q > 32'hffff_ff00)
        wr(`TMRCH_ADDR_CLEAR, 32'h1);
        rd(`TMRCH_ADDR_STATUS, q);
        `CHK("overflow flag", 1'b0, q[1])
        conclude();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        conclude();
    end
endmodule // testbench
bind tmrch_channel tmrch_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .prescaler_clock_0(prescaler_clock_0),
    .prescaler_clock_1(prescaler_clock_1), .prescaler_clock_2(prescaler_clock_2),
    .prescaler_clock_3(prescaler_clock_3), .square_wave_out(square_wave_out),
    .channel_irq(channel_irq));
`default_nettype wire
